// ---- rprs_chk.sv ----
`timescale 1ns/100ps
module rprs_chk #(
    parameter int unsigned POR_CYC = 20,
    parameter int unsigned BUS_CYC = 30,
    parameter int unsigned OFF_CYC = 10
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic wlan_req_level,
    input wire logic sr_req_level,
    input wire logic pulldown_en,
    input wire logic supplies_good_i,
    input wire logic pulldown_disable_i,
    input wire logic regulator_en_o,
    input wire logic wlan_reset_n_o,
    input wire logic shortrange_reset_n_o,
    input wire logic por_active_o,
    input wire logic bus_ready_o
);
    logic any_req;
    logic seen_r;
    logic [1:0] run_r;
    int unsigned off_r, por_r, sg_r;
    assign any_req = wlan_req_level | sr_req_level;
    // run_r keeps $past depth 3 from reaching back into a reset
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_r <= '0;
            seen_r <= 1'b0;
            off_r <= 0;
            por_r <= 0;
            sg_r <= 0;
        end else begin
            run_r <= (run_r == 2'd3) ? run_r : run_r + 2'd1;
            seen_r <= seen_r | any_req;
            off_r <= any_req ? 0 : off_r + 1;
            por_r <= supplies_good_i ? por_r + 32'(por_active_o) : 0;
            sg_r <= supplies_good_i ? sg_r + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence req_rise;
        any_req && !$past(any_req);
    endsequence
    regen_or_a: assert property (run_r == 2'd3 |->
        regulator_en_o == $past(any_req, 3)) else $error("regulator enable");
    regen_off_a: assert property (run_r == 2'd3 && !$past(any_req, 3)
        |-> !regulator_en_o) else $error("regulator left on");
    wlan_rst_a: assert property (run_r == 2'd3 &&
        !$past(wlan_req_level, 3) |-> !wlan_reset_n_o) else $error("wlan rst");
    sr_rst_a: assert property (run_r == 2'd3 &&
        !$past(sr_req_level, 3) |-> !shortrange_reset_n_o) else $error("sr rst");
    por_hold_a: assert property (por_r <= POR_CYC + 6)
        else $error("supply-detect reset too long");
    por_sect_a: assert property (por_active_o |->
        !wlan_reset_n_o && !shortrange_reset_n_o) else $error("reset leak");
    bus_wait_a: assert property (bus_ready_o |-> sg_r >= BUS_CYC - 1)
        else $error("bus ready early");
    bus_drop_a: assert property (!supplies_good_i |=> !bus_ready_o)
        else $error("bus ready kept");
    off_time_a: assert property ((seen_r ##0 req_rise) |->
        $past(off_r) >= OFF_CYC) else $error("off time short");
    pd_track_a: assert property (run_r != 2'd0 |->
        pulldown_en == !$past(pulldown_disable_i)) else $error("pull-down");
endmodule // rprs_chk

// ---- rprs_device.sv ----
`timescale 1ns/100ps
// How it works
// RULE_01: either request high enables the regulators
// RULE_02: both requests low disables the regulators
// RULE_03: wlan section follows its request for reset
// RULE_04: short-range section reset while its request low
// RULE_05: supply-detect reset lasts at most 110 ms
// RULE_06: host waits 150 ms before card-bus access
// RULE_07: host keeps both requests low 10 ms
// RULE_08: all waits minimums; longer is accepted
// RULE_09: request pull-downs on after reset, switchable
// RULE_10: crystal or external reference, no setting
// RULE_11: low-power timing from slow sleep clock
// RULE_12: requests synchronised before any decision
module rprs_device #(
    parameter int unsigned POR_CYC = rprs_pkg::POR_MAX_CYC,
    parameter int unsigned SLOW_DIV = rprs_pkg::INT_SLOW_DIV
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    rprs_if.device link,
    input wire logic supplies_good_i,
    input wire logic pulldown_disable_i,
    input wire logic ext_slow_present_i,
    input wire logic ext_slow_clk_i,
    output logic regulator_en_o,
    output logic wlan_reset_n_o,
    output logic shortrange_reset_n_o,
    output logic por_active_o,
    output logic slow_tick_o
);
    import rprs_pkg::*;

    logic [1:0] wlan_sync_r;
    logic [1:0] sr_sync_r;
    logic [1:0] sup_sync_r;
    logic [1:0] slow_sync_r;
    logic slow_prev_r;
    logic pulldown_r;
    logic [CNT_W-1:0] por_cnt_r;
    logic por_r;
    logic [CNT_W-1:0] div_cnt_r;
    logic wlan_req;
    logic sr_req;

    ////////////////////////////////////////////////////////////////////
    // synchronisers: only stage 2 is read by logic
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wlan_sync_r <= 2'h0;
            sr_sync_r <= 2'h0;
            sup_sync_r <= 2'h0;
            slow_sync_r <= 2'h0;
        end else begin
            wlan_sync_r <= {wlan_sync_r[0], link.wlan_req_level}; // RULE_12
            sr_sync_r <= {sr_sync_r[0], link.sr_req_level}; // RULE_12
            sup_sync_r <= {sup_sync_r[0], supplies_good_i};
            slow_sync_r <= {slow_sync_r[0], ext_slow_clk_i};
        end
    end

    assign wlan_req = wlan_sync_r[1];
    assign sr_req = sr_sync_r[1];

    ////////////////////////////////////////////////////////////////////
    // pad pull-down control
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulldown_r <= PULLDOWN_RESET; // RULE_09
        end else begin
            pulldown_r <= ~pulldown_disable_i; // RULE_09
        end
    end

    assign link.pulldown_en = pulldown_r;

    ////////////////////////////////////////////////////////////////////
    // supply-detect reset: restarts whenever either supply drops,
    // releases after exactly POR_CYC cycles of good supplies
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            por_cnt_r <= '0;
            por_r <= 1'b1;
        end else if (!sup_sync_r[1]) begin
            por_cnt_r <= '0;
            por_r <= 1'b1;
        end else if (por_r) begin
            if (por_cnt_r >= CNT_W'(POR_CYC - 1)) begin
                por_r <= 1'b0; // RULE_05
            end else begin
                por_cnt_r <= por_cnt_r + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // regulator and section resets; any delay before a request edge is
    // accepted since these are pure levels
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            regulator_en_o <= 1'b0;
            wlan_reset_n_o <= 1'b0;
            shortrange_reset_n_o <= 1'b0;
            por_active_o <= 1'b1;
        end else begin
            regulator_en_o <= wlan_req | sr_req; // RULE_01 RULE_02 RULE_08
            wlan_reset_n_o <= wlan_req & ~por_r; // RULE_03
            shortrange_reset_n_o <= sr_req & ~por_r; // RULE_04
            por_active_o <= por_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // slow sleep tick; the fast reference is used as is, whether it comes
    // from a crystal or an external oscillator, with no selection
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt_r <= '0;
            slow_prev_r <= 1'b0;
            slow_tick_o <= 1'b0;
        end else begin
            slow_prev_r <= slow_sync_r[1];
            if (div_cnt_r >= CNT_W'(SLOW_DIV - 1)) begin
                div_cnt_r <= '0;
            end else begin
                div_cnt_r <= div_cnt_r + CNT_W'(1);
            end
            if (ext_slow_present_i) begin
                slow_tick_o <= slow_sync_r[1] & ~slow_prev_r; // RULE_11
            end else begin
                // internal oscillator: wide tolerance, wakeups need margin
                slow_tick_o <= (div_cnt_r >= CNT_W'(SLOW_DIV - 1)); // RULE_11 RULE_10
            end
        end
    end
endmodule // rprs_device

// ---- rprs_host.sv ----
`timescale 1ns/100ps
module rprs_host #(
    parameter int unsigned BUS_CYC = rprs_pkg::BUS_WAIT_CYC,
    parameter int unsigned OFF_CYC = rprs_pkg::OFF_WAIT_CYC
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    rprs_if.host link,
    input wire logic supplies_good_i,
    input wire logic wlan_on_i,
    input wire logic shortrange_on_i,
    output logic bus_ready_o,
    output logic off_wait_o
);
    import rprs_pkg::*;

    logic [CNT_W-1:0] bus_cnt_r;
    logic [CNT_W-1:0] off_cnt_r;
    logic wlan_r;
    logic sr_r;
    logic oe_r;
    logic any_on;

    assign any_on = wlan_on_i | shortrange_on_i;

    ////////////////////////////////////////////////////////////////////
    // card-bus access allowed only after the least wait from supplies good
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_cnt_r <= '0;
            bus_ready_o <= 1'b0;
        end else if (!supplies_good_i) begin
            bus_cnt_r <= '0;
            bus_ready_o <= 1'b0;
        end else if (!bus_ready_o) begin
            if (bus_cnt_r >= CNT_W'(BUS_CYC - 1)) begin
                bus_ready_o <= 1'b1; // RULE_06
            end else begin
                bus_cnt_r <= bus_cnt_r + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request pins; once both are low, neither rises for OFF_CYC cycles.
    // later requests wait longer, which the device accepts
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wlan_r <= 1'b0;
            sr_r <= 1'b0;
            oe_r <= 1'b0;
            off_cnt_r <= '0;
            off_wait_o <= 1'b0;
        end else begin
            oe_r <= 1'b1;
            if (off_wait_o) begin
                if (off_cnt_r >= CNT_W'(OFF_CYC - 1)) begin
                    off_wait_o <= 1'b0; // RULE_07
                end else begin
                    off_cnt_r <= off_cnt_r + CNT_W'(1);
                end
            end else if ((wlan_r | sr_r) && !any_on) begin
                wlan_r <= 1'b0;
                sr_r <= 1'b0;
                off_cnt_r <= '0;
                off_wait_o <= 1'b1; // RULE_07
            end else begin
                wlan_r <= wlan_on_i; // RULE_08
                sr_r <= shortrange_on_i;
            end
        end
    end

    assign link.wlan_req_out = wlan_r;
    assign link.sr_req_out = sr_r;
    assign link.wlan_req_oe = oe_r;
    assign link.sr_req_oe = oe_r;
endmodule // rprs_host

// ---- rprs_if.sv ----
`timescale 1ns/100ps
interface rprs_if;
    logic wlan_req_out;
    logic wlan_req_oe;
    logic sr_req_out;
    logic sr_req_oe;
    logic pulldown_en;
    logic wlan_req_level;
    logic sr_req_level;

    // an undriven pin reads low through the pull-down; with the pull-down
    // off a real pad floats, which is modelled here as low as well
    assign wlan_req_level = wlan_req_oe ? wlan_req_out : 1'b0;
    assign sr_req_level = sr_req_oe ? sr_req_out : 1'b0;

    modport device (
        input wlan_req_level,
        input sr_req_level,
        output pulldown_en
    );
    modport host (
        output wlan_req_out,
        output wlan_req_oe,
        output sr_req_out,
        output sr_req_oe,
        input pulldown_en
    );
endinterface

// ---- rprs_pkg.sv ----
package rprs_pkg;
    // reference clock
    localparam int unsigned REF_CLK_KHZ = 20000;
    localparam int unsigned REF_CLK_MHZ = REF_CLK_KHZ / 1000;

    // supply-detect hold, longest time, in microseconds
    localparam int unsigned POR_MAX_US = 110000;
    // rounded down: a longest time never overshoots
    localparam int unsigned POR_MAX_CYC = (POR_MAX_US * REF_CLK_MHZ) > 0 ?
                                          POR_MAX_US * REF_CLK_MHZ : 1;

    // host wait from supplies good to first card-bus access, least time
    localparam int unsigned BUS_WAIT_US = 150000;
    localparam int unsigned BUS_WAIT_CYC =
        (BUS_WAIT_US * REF_CLK_KHZ + 999) / 1000;

    // host off time between power cycles, least time
    localparam int unsigned OFF_WAIT_US = 10000;
    localparam int unsigned OFF_WAIT_CYC =
        (OFF_WAIT_US * REF_CLK_KHZ + 999) / 1000;

    // internal low-precision sleep oscillator, nominal
    localparam int unsigned INT_SLOW_KHZ = 33;
    localparam int unsigned INT_SLOW_DIV = REF_CLK_KHZ / INT_SLOW_KHZ;

    // pull-down enabled after reset
    localparam logic PULLDOWN_RESET = 1'b1;

    localparam int unsigned CNT_W = 32;
endpackage

// ---- rprs_tb.sv ----
`timescale 1ns/100ps
module rprs_tb;
    logic ref_clk_i = 0, resetn_i = 0, sg = 0, pd_off = 0, wl = 0, sr = 0;
    logic ext_on = 0, ext_clk = 0;
    logic reg_en, wl_rn, sr_rn, por, tick, bus, off_w;
    int fails = 0, checks = 0, cyc = 0;
    rprs_if link();
    rprs_device #(.POR_CYC(20), .SLOW_DIV(8)) u_rprs_device (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link),
        .supplies_good_i(sg), .pulldown_disable_i(pd_off),
        .ext_slow_present_i(ext_on), .ext_slow_clk_i(ext_clk),
        .regulator_en_o(reg_en), .wlan_reset_n_o(wl_rn),
        .shortrange_reset_n_o(sr_rn), .por_active_o(por), .slow_tick_o(tick));
    rprs_host #(.BUS_CYC(30), .OFF_CYC(10)) u_rprs_host (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link),
        .supplies_good_i(sg), .wlan_on_i(wl), .shortrange_on_i(sr),
        .bus_ready_o(bus), .off_wait_o(off_w));
    rprs_chk #(.POR_CYC(20), .BUS_CYC(30), .OFF_CYC(10)) u_rprs_chk (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .wlan_req_level(link.wlan_req_level), .sr_req_level(link.sr_req_level),
        .pulldown_en(link.pulldown_en), .supplies_good_i(sg),
        .pulldown_disable_i(pd_off), .regulator_en_o(reg_en),
        .wlan_reset_n_o(wl_rn), .shortrange_reset_n_o(sr_rn),
        .por_active_o(por), .bus_ready_o(bus));
    ////////////////////////////////////////////////////////////////////
    task step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_power;
        int n;
        n = 0;
        sg = 1;
        while (por !== 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        chk(n <= 26, "supply-detect hold");
        while (bus !== 1'b1 && n < 60) begin
            step(1);
            n++;
        end
        chk(n >= 30 && n < 40, "bus ready wait");
    endtask
    task t_sect;
        wl = 1;
        step(6);
        chk(reg_en === 1'b1 && wl_rn === 1'b1, "wlan up");
        chk(sr_rn === 1'b0, "short-range held");
        sr = 1;
        wl = 0;
        step(6);
        chk(reg_en === 1'b1 && wl_rn === 1'b0 && sr_rn === 1'b1, "swap");
    endtask
    task t_off;
        sr = 0;
        step(2);
        chk(off_w === 1'b1, "off wait");
        // early wish must not reach the pins before the off time ends
        wl = 1;
        step(5);
        chk(reg_en === 1'b0 && wl_rn === 1'b0, "regulators off");
        step(12);
        chk(reg_en === 1'b1, "resume after wait");
    endtask
    task t_tick;
        int n;
        n = 0;
        repeat (80) begin
            step(1);
            if (tick === 1'b1) n++;
        end
        chk(n == 10, "slow tick rate");
    endtask
    // external slow clock: one tick per rising edge, 8 cycles a period
    task t_ext;
        int n;
        n = 0;
        ext_on = 1;
        repeat (5) begin
            ext_clk = 1;
            repeat (4) begin
                step(1);
                if (tick === 1'b1) n++;
            end
            ext_clk = 0;
            repeat (4) begin
                step(1);
                if (tick === 1'b1) n++;
            end
        end
        chk(n == 5, "external slow tick");
        ext_on = 0;
    endtask
    task t_pd;
        pd_off = 1;
        step(2);
        chk(link.pulldown_en === 1'b0, "pull-down off");
        resetn_i = 0;
        step(2);
        chk(link.pulldown_en === 1'b1, "pull-down on in reset");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial forever #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        step(4);
        resetn_i = 1;
        step(2);
        t_power();
        t_sect();
        t_off();
        t_tick();
        t_ext();
        t_pd();
        end_of_test();
    end
endmodule // rprs_tb
